// [bench/dtpb_asserts.sv]
// Port checker for the tuning parameter bank.
// Assumes one clock and answers one edge after a request is taken.
`timescale 1ns/1ns
`default_nettype none
`include "dtpb_defines.svh"
module dtpb_asserts
    import dtpb_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire dtpb_req_s   busReq,
    input wire dtpb_rsp_s   busRsp,
    input wire logic        softwareLockInput,
    input wire logic        freqSettingAllowed,
    input wire logic [15:0] startFrequency,
    input wire logic        clearTripHistory,
    input wire logic        restoreParams,
    input wire logic [1:0]  lastWriteStatus
);
    dtpb_req_s  prevReq;
    logic [1:0] lockMode;
    wire        locked = lockMode[1] || softwareLockInput;
    wire        wrOk   = busRsp.valid && busRsp.ok && prevReq.wrEn;
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            prevReq <= '0;
        else
            prevReq <= busReq;
    // In-range mode writes always land, so the shadow follows the request
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            lockMode <= 2'h0;
        else if (busReq.wrEn && busReq.addr == `DTPB_OFS_LOCK && busReq.data <= 16'h3)
            lockMode <= busReq.data[1:0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_rsp; busReq.wrEn || busReq.rdEn |=> busRsp.valid; endproperty
    a_rsp: assert property (p_rsp) else $error("response missing");
    property p_region; busReq.wrEn && busReq.addr == `DTPB_OFS_REGION |=> busRsp.exception;
    endproperty
    a_region: assert property (p_region) else $error("regional write taken");
    property p_lock; busReq.wrEn && busReq.addr == `DTPB_OFS_GAIN && locked |=> busRsp.exception;
    endproperty
    a_lock: assert property (p_lock) else $error("locked write taken");
    property p_lock_free;
        busReq.wrEn && busReq.addr == `DTPB_OFS_LOCK && busReq.data <= 16'h3 |=> busRsp.ok;
    endproperty
    a_lock_free: assert property (p_lock_free) else $error("mode write refused");
    property p_range;
        busReq.wrEn && busReq.addr == `DTPB_OFS_START && busReq.data > 16'h63 && !locked
            |=> busRsp.exception && lastWriteStatus == DTPB_WR_RANGE;
    endproperty
    a_range: assert property (p_range) else $error("range not refused");
    property p_init;
        wrOk && prevReq.addr == `DTPB_OFS_INIT |-> clearTripHistory == (prevReq.data != 16'h1)
            && restoreParams == (prevReq.data != 16'h0);
    endproperty
    a_init: assert property (p_init) else $error("init pulses wrong");
    property p_start; wrOk && prevReq.addr == `DTPB_OFS_START |-> startFrequency == prevReq.data;
    endproperty
    a_start: assert property (p_start) else $error("start value wrong");
    property p_freq;
        $past(rstn) |-> freqSettingAllowed == ($past(lockMode[0]) || !$past(locked));
    endproperty
    a_freq: assert property (p_freq) else $error("frequency permit wrong");
endmodule : dtpb_asserts
bind dtpb_param_bank dtpb_asserts u_chk (.*);
`default_nettype wire

// [bench/dtpb_net_master.sv]
// Network master model issuing holding register reads and writes.
// Assumes requests are taken on the rising edge of clk_sys.
`timescale 1ns/1ns
`default_nettype none
module dtpb_net_master
    import dtpb_pkg::*;
(
    input  wire logic      clk_sys,
    output var  dtpb_req_s busReq,
    input  wire dtpb_rsp_s busRsp
);
    dtpb_word_t lastRead;
    initial busReq = '0;
    // Released lines carry noise, never the last request
    task automatic xfer(input logic wr, input dtpb_word_t a, input dtpb_word_t d);
        @(posedge clk_sys);
        #1 busReq = '{wrEn: wr, rdEn: !wr, addr: a, data: d};
        @(posedge clk_sys);
        #1 busReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: 16'($urandom), data: 16'($urandom)};
    endtask : xfer
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : idle
    always @(posedge clk_sys)
        if (busRsp.valid === 1'b1)
            lastRead <= busRsp.data;
endmodule : dtpb_net_master
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the tuning parameter bank.
// Assumes the network master model and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
`include "dtpb_defines.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top
    import dtpb_pkg::*;
();
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        softwareLockInput = 1'b0;
    logic [15:0] outputFreq = 16'h0;
    dtpb_req_s   busReq;
    dtpb_rsp_s   busRsp;
    logic        freqSettingAllowed, brakeEnabled, stopCoast, stopKeyEnabled;
    logic        restartMatched, overloadSrcAnalog1, overloadSrcAnalog2;
    logic [31:0] scaledFreqMonitor;
    logic [15:0] overloadDecelRate, carrierFrequency, brakeUsage;
    logic [7:0]  analogMonitorGain;
    logic        freqSettingWrite = 1'b0;
    logic [17:0] expQ[$];
    logic [17:0] expHead;
    dtpb_word_t  r, mid;
    int          errors = 0;
    int          checked = 0;
    int          cycles = 0;
    wire  [5:0]  flags = {brakeEnabled, stopCoast, stopKeyEnabled, restartMatched,
                          overloadSrcAnalog1, overloadSrcAnalog2};
    dtpb_word_t  offs[14] = '{16'h10b7, 16'h10bb, 16'h10bc, 16'h10cf, 16'h10d1, 16'h10d2,
        16'h10d3, 16'h10d4, 16'h10d5, 16'h10d6, 16'h10d7, 16'h10d9, 16'h10da, 16'h152b};
    dtpb_word_t  mins[14] = '{16'h1, 16'h0, 16'h0, 16'h0, 16'h5, 16'h14, 16'h0, 16'h0, 16'h1,
        16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    dtpb_word_t  maxs[14] = '{16'h12c, 16'h1, 16'h3, 16'hff, 16'h63, 16'h8c, 16'h2, 16'h0,
        16'h3e7, 16'h1, 16'h1, 16'h3e8, 16'h1, 16'h1};
    dtpb_word_t  rsts[14] = '{16'ha, 16'h0, 16'h0, 16'h64, 16'h5, 16'h50, 16'h0, 16'h0, 16'ha,
        16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    dtpb_word_t  fOffs[6] = '{16'h10d9, 16'h10da, 16'h10d6, 16'h10d7, 16'h10bb, 16'h152b};
    dtpb_net_master u_master (.clk_sys(clk_sys), .busReq(busReq), .busRsp(busRsp));
    dtpb_param_bank #(.FREQ_W(16)) DUT
    (
        .*, .startFrequency(), .clearTripHistory(), .restoreParams(), .lastWriteStatus()
    );
    always #5 clk_sys = ~clk_sys;
    task automatic op(input logic wr, input dtpb_word_t a, input dtpb_word_t d, input logic exc);
        expQ.push_back({!wr, exc, wr ? 16'h0 : d});
        u_master.xfer(wr, a, wr ? d : 16'($urandom));
    endtask : op
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    always @(posedge clk_sys)
        if (busRsp.valid === 1'b1)
        begin
            expHead = expQ.pop_front();
            `CHK(busRsp.exception, expHead[16])
            if (expHead[17])
                `CHK(busRsp.data, expHead[15:0])
        end
    // Ceiling well above the few hundred cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        void'($urandom(32'h25ca));
        repeat (20) @(posedge clk_sys);
        #1 rstn = 1'b1;
        for (int i = 0; i < 14; i++)
            op(1'b0, offs[i], rsts[i], 1'b0);
        op(1'b0, 16'h10b8, 16'h0, 1'b1);
        op(1'b1, 16'h10b8, 16'h1, 1'b1);
        $display("Test reset values done");
        for (int i = 0; i < 14; i++)
        begin
            mid = (mins[i] + maxs[i]) >> 1;
            r = 16'($urandom_range(maxs[i], mins[i]));
            op(1'b1, offs[i], mins[i], i == 7);
            op(1'b1, offs[i], maxs[i] + 16'h1, 1'b1);
            op(1'b1, offs[i], mid, i == 7);
            op(1'b1, offs[i], mins[i] - 16'h1, 1'b1);
            op(1'b0, offs[i], mid, 1'b0);
            op(1'b1, offs[i], maxs[i], i == 7);
            op(1'b1, offs[i], r, i == 7);
            op(1'b0, offs[i], r, 1'b0);
            if (i == 2)
                op(1'b1, offs[i], 16'h0, 1'b0);
        end
        $display("Test ranges done");
        for (int m = 0; m < 4; m++)
            for (int t = 0; t < 2; t++)
            begin
                op(1'b1, `DTPB_OFS_LOCK, 16'(m), 1'b0);
                u_master.idle(1);
                softwareLockInput = t[0];
                freqSettingWrite = 1'($urandom);
                u_master.idle(2);
                `CHK(freqSettingAllowed, m[0] || !(m[1] || t[0]))
                op(1'b1, `DTPB_OFS_GAIN, 16'($urandom_range(255)), m[1] || t[0]);
            end
        softwareLockInput = 1'b0;
        op(1'b1, `DTPB_OFS_LOCK, 16'h0, 1'b0);
        $display("Test lock modes done");
        r = 16'($urandom_range(300, 1));
        mid = 16'($urandom_range(140, 20));
        op(1'b1, `DTPB_OFS_DECEL, r, 1'b0);
        op(1'b1, `DTPB_OFS_CARRIER, mid, 1'b0);
        op(1'b1, `DTPB_OFS_GAIN, r & 16'h00ff, 1'b0);
        op(1'b0, `DTPB_OFS_DECEL, r, 1'b0);
        u_master.idle(1);
        `CHK(u_master.lastRead, r)
        `CHK(overloadDecelRate, r)
        `CHK(carrierFrequency, mid)
        `CHK(analogMonitorGain, r[7:0])
        for (int s = 0; s < 2; s++)
        begin
            for (int i = 0; i < 6; i++)
                op(1'b1, fOffs[i], i == 0 ? 16'(s) * 16'h3e8 : 16'(s == 0), 1'b0);
            u_master.idle(2);
            `CHK(flags, s ? 6'h28 : 6'h17)
            `CHK(brakeUsage, 16'(s) * 16'h3e8)
        end
        op(1'b1, `DTPB_OFS_SCALE, 16'h3e7, 1'b0);
        outputFreq = 16'($urandom);
        u_master.idle(3);
        `CHK(scaledFreqMonitor, 32'(outputFreq) * 32'h3e7 / 32'ha)
        $display("Test outputs done");
        u_master.idle(3);
        conclude();
    end
endmodule : tb_top
`default_nettype wire

// [include/dtpb_defines.svh]
// Register numbers, ranges and reset values of the tuning parameter bank.
// Assumes registers are addressed by 16-bit holding register number.
`ifndef DTPB_DEFINES_SVH
`define DTPB_DEFINES_SVH

`define DTPB_OFS_DECEL        16'h10b7
`define DTPB_OFS_SRC1         16'h10bb
`define DTPB_OFS_LOCK         16'h10bc
`define DTPB_OFS_GAIN         16'h10cf
`define DTPB_OFS_START        16'h10d1
`define DTPB_OFS_CARRIER      16'h10d2
`define DTPB_OFS_INIT         16'h10d3
`define DTPB_OFS_REGION       16'h10d4
`define DTPB_OFS_SCALE        16'h10d5
`define DTPB_OFS_STOPKEY      16'h10d6
`define DTPB_OFS_RESTART      16'h10d7
`define DTPB_OFS_BRAKE        16'h10d9
`define DTPB_OFS_STOPMODE     16'h10da
`define DTPB_OFS_SRC2         16'h152b

`define DTPB_MIN_DECEL        16'h0001
`define DTPB_MAX_DECEL        16'h012c
`define DTPB_MAX_SRC          16'h0001
`define DTPB_MAX_LOCK         16'h0003
`define DTPB_MAX_GAIN         16'h00ff
`define DTPB_MIN_START        16'h0005
`define DTPB_MAX_START        16'h0063
`define DTPB_MIN_CARRIER      16'h0014
`define DTPB_MAX_CARRIER      16'h008c
`define DTPB_MAX_INIT         16'h0002
`define DTPB_MIN_SCALE        16'h0001
`define DTPB_MAX_SCALE        16'h03e7
`define DTPB_MAX_BIT          16'h0001
`define DTPB_MAX_BRAKE        16'h03e8

`define DTPB_RST_DECEL        16'h000a
`define DTPB_RST_GAIN         16'h0064
`define DTPB_RST_START        16'h0005
`define DTPB_RST_CARRIER      16'h0050
`define DTPB_RST_SCALE        16'h000a
`define DTPB_RST_REGION       16'h0000
`define DTPB_RST_ZERO         16'h0000

`define DTPB_LOCK_SFT         16'h0000
`define DTPB_LOCK_SFT_FREQ    16'h0001
`define DTPB_LOCK_ALL         16'h0002
`define DTPB_LOCK_ALL_FREQ    16'h0003

`define DTPB_NUM_REGS         14
`define DTPB_IDX_REGION       7
`define DTPB_IDX_LOCK         2
`define DTPB_IDX_STOPMODE     12
`endif

// [include/dtpb_pkg.sv]
// Types shared by the tuning parameter bank.
// Assumes the defines header is compiled alongside.
package dtpb_pkg;
    typedef logic [15:0] dtpb_word_t;

    typedef struct packed
    {
        logic       wrEn;
        logic       rdEn;
        dtpb_word_t addr;
        dtpb_word_t data;
    } dtpb_req_s;

    typedef struct packed
    {
        logic       valid;
        logic       ok;
        logic       exception;
        dtpb_word_t data;
    } dtpb_rsp_s;

    typedef enum logic [1:0]
    {
        DTPB_WR_OK       = 2'b00,
        DTPB_WR_LOCKED   = 2'b01,
        DTPB_WR_RANGE    = 2'b10,
        DTPB_WR_READONLY = 2'b11
    } dtpb_wr_status_e;
endpackage : dtpb_pkg

// [logic/dtpb_param_bank.sv]
// Holding register bank of drive fine-tuning parameters.
// Assumes a fieldbus front end delivers one-cycle request strobes.
`timescale 1ns/1ns
`default_nettype none
`include "dtpb_defines.svh"

// Notes on behaviour
// - Decel rate 1..300, 0.1 s steps
// - Per-motor source: 00 stored level, 01 analog
// - Mode 00: lock all but mode when input
// - Mode 01: also frequency free when input
// - Mode 02: lock all but mode always
// - Mode 03: mode and frequency free always
// - Monitor gain 0..255
// - Start frequency 5..99, 0.1 Hz steps
// - Carrier 20..140, tenth units
// - Init type 00 trip, 01 params, 02 both
// - Scale 1..999 multiplies frequency monitor
// - Stop key 00 enabled, 01 disabled
// - Coast cancel restart 0 Hz or matched
// - Brake ratio 0 off, 1..1000 enables
// - Stop mode 00 decelerate, 01 coast
// - Registers addressed by holding register number
module dtpb_param_bank
    import dtpb_pkg::*;
#(
    parameter int FREQ_W = 16
)
(
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire dtpb_req_s         busReq,
    output var  dtpb_rsp_s         busRsp,
    input  wire logic              softwareLockInput,
    input  wire logic              freqSettingWrite,
    input  wire logic [FREQ_W-1:0] outputFreq,
    output var  logic              freqSettingAllowed,
    output var  logic [15:0]       overloadDecelRate,
    output var  logic              overloadSrcAnalog1,
    output var  logic              overloadSrcAnalog2,
    output var  logic [7:0]        analogMonitorGain,
    output var  logic [15:0]       startFrequency,
    output var  logic [15:0]       carrierFrequency,
    output var  logic              clearTripHistory,
    output var  logic              restoreParams,
    output var  logic [31:0]       scaledFreqMonitor,
    output var  logic              stopKeyEnabled,
    output var  logic              restartMatched,
    output var  logic              brakeEnabled,
    output var  logic [15:0]       brakeUsage,
    output var  logic              stopCoast,
    output var  logic [1:0]        lastWriteStatus
);
    localparam int N  = `DTPB_NUM_REGS;
    localparam int IW = $clog2(N);

    wire dtpb_word_t regOfs [N];
    wire dtpb_word_t regMin [N];
    wire dtpb_word_t regMax [N];

    // Table order matches the register index used everywhere below
    assign regOfs[0]  = `DTPB_OFS_DECEL;
    assign regOfs[1]  = `DTPB_OFS_SRC1;
    assign regOfs[2]  = `DTPB_OFS_LOCK;
    assign regOfs[3]  = `DTPB_OFS_GAIN;
    assign regOfs[4]  = `DTPB_OFS_START;
    assign regOfs[5]  = `DTPB_OFS_CARRIER;
    assign regOfs[6]  = `DTPB_OFS_INIT;
    assign regOfs[7]  = `DTPB_OFS_REGION;
    assign regOfs[8]  = `DTPB_OFS_SCALE;
    assign regOfs[9]  = `DTPB_OFS_STOPKEY;
    assign regOfs[10] = `DTPB_OFS_RESTART;
    assign regOfs[11] = `DTPB_OFS_BRAKE;
    assign regOfs[12] = `DTPB_OFS_STOPMODE;
    assign regOfs[13] = `DTPB_OFS_SRC2;

    assign regMin[0]  = `DTPB_MIN_DECEL;
    assign regMax[0]  = `DTPB_MAX_DECEL;
    assign regMin[1]  = `DTPB_RST_ZERO;
    assign regMax[1]  = `DTPB_MAX_SRC;
    assign regMin[2]  = `DTPB_RST_ZERO;
    assign regMax[2]  = `DTPB_MAX_LOCK;
    assign regMin[3]  = `DTPB_RST_ZERO;
    assign regMax[3]  = `DTPB_MAX_GAIN;
    assign regMin[4]  = `DTPB_MIN_START;
    assign regMax[4]  = `DTPB_MAX_START;
    assign regMin[5]  = `DTPB_MIN_CARRIER;
    assign regMax[5]  = `DTPB_MAX_CARRIER;
    assign regMin[6]  = `DTPB_RST_ZERO;
    assign regMax[6]  = `DTPB_MAX_INIT;
    assign regMin[7]  = `DTPB_RST_ZERO;
    assign regMax[7]  = `DTPB_RST_ZERO;
    assign regMin[8]  = `DTPB_MIN_SCALE;
    assign regMax[8]  = `DTPB_MAX_SCALE;
    assign regMin[9]  = `DTPB_RST_ZERO;
    assign regMax[9]  = `DTPB_MAX_BIT;
    assign regMin[10] = `DTPB_RST_ZERO;
    assign regMax[10] = `DTPB_MAX_BIT;
    assign regMin[11] = `DTPB_RST_ZERO;
    assign regMax[11] = `DTPB_MAX_BRAKE;
    assign regMin[12] = `DTPB_RST_ZERO;
    assign regMax[12] = `DTPB_MAX_BIT;
    assign regMin[13] = `DTPB_RST_ZERO;
    assign regMax[13] = `DTPB_MAX_SRC;

    // Reset image is a constant so the async branch loads no logic
    localparam dtpb_word_t REG_RST [N] = '{
        `DTPB_RST_DECEL,
        `DTPB_RST_ZERO,
        `DTPB_RST_ZERO,
        `DTPB_RST_GAIN,
        `DTPB_RST_START,
        `DTPB_RST_CARRIER,
        `DTPB_RST_ZERO,
        `DTPB_RST_REGION,
        `DTPB_RST_SCALE,
        `DTPB_RST_ZERO,
        `DTPB_RST_ZERO,
        `DTPB_RST_ZERO,
        `DTPB_RST_ZERO,
        `DTPB_RST_ZERO
    };

    dtpb_word_t  bank_reg [N];
    dtpb_rsp_s   rsp_reg;
    logic [1:0]  status_reg;
    logic        freqAllow_reg;
    logic        clrTrip_reg;
    logic        restore_reg;
    logic        brakeEn_reg;
    logic        stopKeyEn_reg;

    wire logic [N-1:0] hit;
    wire logic         anyHit;
    wire dtpb_word_t   rdData;
    wire logic         sftLock;
    wire logic         lockAll;
    wire logic         freqFree;
    wire logic         inRange;
    wire logic         isLockReg;
    wire logic         isReadOnly;
    wire logic         wrAccept;
    wire logic         initTrigger;
    wire dtpb_word_t   lockMode;
    wire dtpb_word_t   hitMin;
    wire dtpb_word_t   hitMax;
    wire dtpb_word_t   hitIdx;
    wire logic         modeSft;
    wire logic         modeSftFreq;
    wire logic         modeAll;
    wire logic         modeAllFreq;
    wire logic         anyReq;
    wire logic         reqOk;
    wire logic         initClear;
    wire logic         initRestore;
    wire logic         brakeWrite;
    wire logic         stopKeyWrite;
    wire logic         brakeEn_next;
    wire logic         stopKeyEn_next;
    dtpb_wr_status_e   wrStatus;

    // Exact number match; anything else answers with an exception
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : gDecode
            assign hit[g] = (busReq.addr == regOfs[g]);
        end
    endgenerate

    function automatic dtpb_word_t pickWord(input dtpb_word_t vals [N],
                                            input logic [N-1:0] sel);
        dtpb_word_t r;
        r = 16'h0000;
        for (int i = 0; i < N; i++)
        begin
            if (sel[i])
                r = vals[i];
        end
        return r;
    endfunction : pickWord

    function automatic dtpb_word_t pickIdx(input logic [N-1:0] sel);
        dtpb_word_t r;
        r = 16'h0000;
        for (int i = 0; i < N; i++)
        begin
            if (sel[i])
                r = 16'(i);
        end
        return r;
    endfunction : pickIdx

    assign anyHit     = |hit;
    // Read path goes through the decoded index, one mux over the flop array
    assign rdData     = anyHit ? bank_reg[hitIdx[IW-1:0]] : 16'h0000;
    assign hitMin     = pickWord(regMin, hit);
    assign hitMax     = pickWord(regMax, hit);
    assign hitIdx     = pickIdx(hit);
    assign lockMode   = bank_reg[`DTPB_IDX_LOCK];
    assign isLockReg  = hit[`DTPB_IDX_LOCK];
    assign isReadOnly = hit[`DTPB_IDX_REGION];
    assign inRange    = (busReq.data >= hitMin) && (busReq.data <= hitMax);

    assign modeSft     = (lockMode == `DTPB_LOCK_SFT);
    assign modeSftFreq = (lockMode == `DTPB_LOCK_SFT_FREQ);
    assign modeAll     = (lockMode == `DTPB_LOCK_ALL);
    assign modeAllFreq = (lockMode == `DTPB_LOCK_ALL_FREQ);

    // Mode 00/01 lock only while the terminal is on; 02/03 always
    assign sftLock  = (modeSft || modeSftFreq) && softwareLockInput;
    assign lockAll  = sftLock || modeAll || modeAllFreq;
    assign freqFree = modeSftFreq || modeAllFreq;

    always_comb
    begin
        if (isReadOnly)
            wrStatus = DTPB_WR_READONLY;
        else if (lockAll && !isLockReg)
            wrStatus = DTPB_WR_LOCKED;
        else if (!inRange)
            wrStatus = DTPB_WR_RANGE;
        else
            wrStatus = DTPB_WR_OK;
    end

    assign wrAccept    = busReq.wrEn && anyHit && (wrStatus == DTPB_WR_OK);
    // Init is a one-shot action fired by an accepted write
    assign initTrigger = wrAccept && hit[6];
    assign initClear   = initTrigger && (busReq.data != 16'h0001);
    assign initRestore = initTrigger && (busReq.data != 16'h0000);
    // Ok only for a real request, so idle cycles show a clean response
    assign anyReq      = busReq.wrEn || busReq.rdEn;
    assign reqOk       = anyHit && (busReq.rdEn || wrStatus == DTPB_WR_OK);

    // Derived flags sit in their own flops so the outputs carry no gates
    assign brakeWrite     = wrAccept && hit[11];
    assign stopKeyWrite   = wrAccept && hit[9];
    assign brakeEn_next   = brakeWrite ? (busReq.data != 16'h0000) : brakeEn_reg;
    assign stopKeyEn_next = stopKeyWrite ? !busReq.data[0] : stopKeyEn_reg;

    generate
        for (g = 0; g < N; g++)
        begin : gBank
            always_ff @(posedge clk_sys or negedge rstn)
            begin
                if (!rstn)
                    bank_reg[g] <= REG_RST[g];
                else if (wrAccept && hit[g])
                    bank_reg[g] <= busReq.data;
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rsp_reg <= '0;
        else
        begin
            rsp_reg.valid     <= anyReq;
            rsp_reg.ok        <= anyReq && reqOk;
            rsp_reg.exception <= anyReq && !reqOk;
            rsp_reg.data      <= (busReq.rdEn && anyHit) ? rdData : 16'h0000;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            status_reg <= 2'b00;
        else if (busReq.wrEn && anyHit)
            status_reg <= wrStatus;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            brakeEn_reg   <= 1'b0;
            stopKeyEn_reg <= 1'b1;
        end
        else
        begin
            brakeEn_reg   <= brakeEn_next;
            stopKeyEn_reg <= stopKeyEn_next;
        end
    end

    // Output frequency setting is steered by the same lock state
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            freqAllow_reg <= 1'b1;
        else
            freqAllow_reg <= !lockAll || freqFree;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            clrTrip_reg <= 1'b0;
            restore_reg <= 1'b0;
        end
        else
        begin
            clrTrip_reg <= initClear;
            restore_reg <= initRestore;
        end
    end

    dtpb_scale_mult #(
        .FREQ_W    (FREQ_W)
    ) uScale (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .freqIn    (outputFreq),
        .scaleIn   (bank_reg[8]),
        .scaledOut (scaledFreqMonitor)
    );

    // Decoded fields are flop outputs; bank entries are flops themselves
    assign busRsp             = rsp_reg;
    assign lastWriteStatus    = status_reg;
    assign freqSettingAllowed = freqAllow_reg;
    assign clearTripHistory   = clrTrip_reg;
    assign restoreParams      = restore_reg;
    assign overloadDecelRate  = bank_reg[0];
    assign overloadSrcAnalog1 = bank_reg[1][0];
    assign overloadSrcAnalog2 = bank_reg[13][0];
    assign analogMonitorGain  = bank_reg[3][7:0];
    assign startFrequency     = bank_reg[4];
    assign carrierFrequency   = bank_reg[5];
    assign stopKeyEnabled     = stopKeyEn_reg;
    assign restartMatched     = bank_reg[10][0];
    assign brakeEnabled       = brakeEn_reg;
    assign brakeUsage         = bank_reg[11];
    assign stopCoast          = bank_reg[`DTPB_IDX_STOPMODE][0];
endmodule : dtpb_param_bank
`default_nettype wire

// [logic/dtpb_scale_mult.sv]
// Scaled frequency monitor: frequency times display constant over ten.
// Assumes frequency in 0.01 Hz counts and scale in 0.1 counts.
`timescale 1ns/1ns
`default_nettype none
module dtpb_scale_mult
    import dtpb_pkg::*;
#(
    parameter int FREQ_W = 16
)
(
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic [FREQ_W-1:0] freqIn,
    input  wire logic [15:0]       scaleIn,
    output var  logic [31:0]       scaledOut
);
    wire logic [FREQ_W+15:0] product;
    wire logic [31:0]        quotient;
    logic      [31:0]        scaled_reg;

    assign product   = freqIn * scaleIn;
    // Constant divide by ten; scale carries one decimal place
    assign quotient  = 32'(product / (FREQ_W+16)'(10));
    assign scaledOut = scaled_reg;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            scaled_reg <= 32'h0;
        else
            scaled_reg <= quotient;
    end
endmodule : dtpb_scale_mult
`default_nettype wire
